// ===== rtl/rtc_calendar_defs.vh
// Register offsets, field positions, reset values and timing for the calendar clock
`ifndef RTC_CALENDAR_DEFS_VH
`define RTC_CALENDAR_DEFS_VH

// ----------------------------------------
// Register offsets (word index on the plain port)
// ----------------------------------------
`define OFS_MAIN_CTRL     3'h0
`define OFS_LAP_CTRL      3'h1
`define OFS_SEC_DIV       3'h2
`define OFS_HOUR_MIN      3'h3
`define OFS_MONTH_DAY     3'h4
`define OFS_YEAR_WEEK     3'h5
`define OFS_EVENT_FLAGS   3'h6
`define OFS_EVENT_ENABLE  3'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_RUN           0
`define BIT_DIV_CLEAR     1
`define BIT_FULL_DAY      4
`define BIT_BUSY          6
`define BIT_LAP_GO        0
`define BIT_LAP_CLEAR     4
`define BIT_HALF_DAY      14
`define FLAG_MASK         16'hf1ff

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_HOUR_TENS     2'h1
`define RST_HOUR_UNITS    4'h2
`define RST_MONTH_UNITS   4'h1
`define RST_DAY_UNITS     4'h1

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ            200000000
`define DIV_TICK_HZ       256
`define LAP_TICK_HZ       100
`define DIV_TICK_CYCLES   (`CLK_HZ / `DIV_TICK_HZ)
`define LAP_TICK_CYCLES   (`CLK_HZ / `LAP_TICK_HZ)

`endif

// ===== rtl/rtc_calendar_stopwatch_regs.v
// Calendar clock, 1 Hz divider, lap timer and event flags behind a plain register port
//
// Behaviour
// - Lap clear while running restarts count from zero; while idle count holds zero.
// - Lap clear bit always reads zero.
// - Clearing go freezes the lap count; setting it resumes from the frozen value.
// - Lap stop takes effect at the next lap tick, so one more step may occur.
// - Seconds are BCD 0..59, tens in bits 14:12, units in bits 11:8, read/write.
// - Seconds register bits 7:0 read the divider stages, 1 Hz at bit 7; read-only.
// - Setting the divider clear bit zeroes all eight divider stages.
// - In 12-hour mode bit 14 holds the half-day bit, one for afternoon.
// - In 24-hour mode half-day reads zero, ignores ones, clears at next hour step.
// - Hours BCD in 13:12 and 11:8, 1..12 or 0..23, reset to twelve.
// - Minutes BCD 0..59, tens in 6:4, units in 3:0, reset to zero.
// - Month BCD 1..12, tens at bit 12, units in 11:8, reset to one.
// - Day BCD in bits 5:0, reset one, limit by month and leap year.
// - Weekday in bits 10:8 counts 0..6, zero is Sunday.
// - Year BCD 0..99, tens in 7:4, units in 3:0, reset to zero.
// - Flags set on their cause; writing one clears, writing zero does nothing.
// - Flag bits: 15 regulation, 14..12 lap events, 8 alarm, 7..0 time events.
// - Busy rises on each second step and holds for 1/256 second.
// - Full-day select picks 24-hour range without converting stored hours.
// - Each cause has an enable; request is high when flag and enable both are.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "rtc_calendar_defs.vh"

module rtc_calendar_stopwatch_regs
#(
   parameter DIV_TICK_CYCLES = `DIV_TICK_CYCLES,
   parameter LAP_TICK_CYCLES = `LAP_TICK_CYCLES
)
(
   input  wire        clk_in,
   input  wire        rst_n_in,
   input  wire [2:0]  addr_in,
   input  wire [15:0] wdata_in,
   input  wire        wr_in,
   input  wire        rd_in,
   input  wire        alarm_in,
   input  wire        regulation_done_in,
   output reg  [15:0] rdata_out,
   output reg         irq_out
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function [3:0] inc4;
      input [3:0] v;
      begin
         inc4 = v + 4'h1;
      end
   endfunction

   // Last day of the month in BCD, leap years by year divisible by four
   function [5:0] last_day;
      input       mo_t;
      input [3:0] mo_u;
      input [3:0] yr_t;
      input [3:0] yr_u;
      reg         leap;
      begin
         leap = yr_t[0] ? (yr_u == 4'h2 || yr_u == 4'h6)
                        : (yr_u == 4'h0 || yr_u == 4'h4 || yr_u == 4'h8);
         if (!mo_t && mo_u == 4'h2)
            last_day = leap ? 6'h29 : 6'h28;
         else if ((!mo_t && (mo_u == 4'h4 || mo_u == 4'h6 || mo_u == 4'h9)) ||
                  (mo_t && mo_u == 4'h1))
            last_day = 6'h30;
         else
            last_day = 6'h31;
      end
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   reg        run_q;
   reg        div_clear_q;
   reg        full_day_q;
   reg        busy_q;
   reg        lap_go_q;
   reg        lap_active_q;
   reg [3:0]  lap_tenths_q;
   reg [3:0]  lap_hundredths_q;
   reg [31:0] div_pre_q;
   reg [31:0] lap_pre_q;
   reg [7:0]  div_q;
   reg [2:0]  sec_t_q;
   reg [3:0]  sec_u_q;
   reg [2:0]  min_t_q;
   reg [3:0]  min_u_q;
   reg        half_day_q;
   reg [1:0]  hr_t_q;
   reg [3:0]  hr_u_q;
   reg        mo_t_q;
   reg [3:0]  mo_u_q;
   reg [1:0]  day_t_q;
   reg [3:0]  day_u_q;
   reg [2:0]  week_q;
   reg [3:0]  yr_t_q;
   reg [3:0]  yr_u_q;
   reg [15:0] flags_q;
   reg [15:0] enable_q;

   wire div_tick = (div_pre_q == DIV_TICK_CYCLES - 1);
   wire lap_tick = (lap_pre_q == LAP_TICK_CYCLES - 1);
   wire step     = div_tick && run_q && !div_clear_q;
   wire sec_step = step && (div_q == 8'hff);
   wire wr_main  = wr_in && (addr_in == `OFS_MAIN_CTRL);
   wire wr_lap   = wr_in && (addr_in == `OFS_LAP_CTRL);
   wire wr_sec   = wr_in && (addr_in == `OFS_SEC_DIV);
   wire wr_hm    = wr_in && (addr_in == `OFS_HOUR_MIN);
   wire wr_md    = wr_in && (addr_in == `OFS_MONTH_DAY);
   wire wr_yw    = wr_in && (addr_in == `OFS_YEAR_WEEK);
   wire wr_flag  = wr_in && (addr_in == `OFS_EVENT_FLAGS);
   wire wr_en    = wr_in && (addr_in == `OFS_EVENT_ENABLE);

   // Cascade carries
   wire sec_wrap = sec_step && sec_t_q == 3'h5 && sec_u_q == 4'h9;
   wire min_wrap = sec_wrap && min_t_q == 3'h5 && min_u_q == 4'h9;
   wire hr_last  = full_day_q ? (hr_t_q == 2'h2 && hr_u_q == 4'h3)
                              : (hr_t_q == 2'h1 && hr_u_q == 4'h1 && half_day_q);
   wire day_wrap = min_wrap && hr_last;
   wire day_last = ({day_t_q, day_u_q} == last_day(mo_t_q, mo_u_q, yr_t_q, yr_u_q));
   wire mo_wrap  = day_wrap && day_last;
   wire yr_step  = mo_wrap && mo_t_q && mo_u_q == 4'h2;

   // Lap timer carries
   wire lap_step = lap_tick && lap_active_q;
   wire lap_10   = lap_step && lap_hundredths_q == 4'h9;
   wire lap_1    = lap_10 && lap_tenths_q == 4'h9;

   // ----------------------------------------
   // Main control, prescalers, divider
   // ----------------------------------------
   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         run_q       <= 1'b0;
         div_clear_q <= 1'b0;
         full_day_q  <= 1'b0;
         busy_q      <= 1'b0;
         div_pre_q   <= 32'h0;
         lap_pre_q   <= 32'h0;
         div_q       <= 8'h00;
      end
      else
      begin
         if (wr_main)
         begin
            run_q      <= wdata_in[`BIT_RUN];
            full_day_q <= wdata_in[`BIT_FULL_DAY];
         end
         // Clear is held one cycle so software can see it in progress
         div_clear_q <= wr_main && wdata_in[`BIT_DIV_CLEAR];
         if (div_clear_q || div_tick)
            div_pre_q <= 32'h0;
         else
            div_pre_q <= div_pre_q + 32'h1;
         lap_pre_q <= lap_tick ? 32'h0 : lap_pre_q + 32'h1;
         if (div_clear_q)
            div_q <= 8'h00;
         else if (step)
            div_q <= div_q + 8'h01;
         // Busy spans exactly one divider tick after the second step
         if (sec_step)
            busy_q <= 1'b1;
         else if (div_tick || div_clear_q)
            busy_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Lap timer
   // ----------------------------------------
   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         lap_go_q         <= 1'b0;
         lap_active_q     <= 1'b0;
         lap_tenths_q     <= 4'h0;
         lap_hundredths_q <= 4'h0;
      end
      else
      begin
         if (wr_lap)
            lap_go_q <= wdata_in[`BIT_LAP_GO];
         // Go is sampled only on the lap tick, so a stop may allow one last step
         if (lap_tick)
            lap_active_q <= lap_go_q;
         if (wr_lap && wdata_in[`BIT_LAP_CLEAR])
         begin
            lap_tenths_q     <= 4'h0;
            lap_hundredths_q <= 4'h0;
         end
         else if (lap_step)
         begin
            lap_hundredths_q <= lap_10 ? 4'h0 : inc4(lap_hundredths_q);
            if (lap_10)
               lap_tenths_q <= lap_1 ? 4'h0 : inc4(lap_tenths_q);
         end
      end
   end

   // ----------------------------------------
   // Calendar counters
   // ----------------------------------------
   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sec_t_q    <= 3'h0;
         sec_u_q    <= 4'h0;
         min_t_q    <= 3'h0;
         min_u_q    <= 4'h0;
         half_day_q <= 1'b0;
         hr_t_q     <= `RST_HOUR_TENS;
         hr_u_q     <= `RST_HOUR_UNITS;
         mo_t_q     <= 1'b0;
         mo_u_q     <= `RST_MONTH_UNITS;
         day_t_q    <= 2'h0;
         day_u_q    <= `RST_DAY_UNITS;
         week_q     <= 3'h0;
         yr_t_q     <= 4'h0;
         yr_u_q     <= 4'h0;
      end
      else
      begin
         // Seconds
         if (wr_sec)
         begin
            sec_t_q <= wdata_in[14:12];
            sec_u_q <= wdata_in[11:8];
         end
         else if (sec_step)
         begin
            sec_u_q <= (sec_u_q == 4'h9) ? 4'h0 : inc4(sec_u_q);
            if (sec_u_q == 4'h9)
               sec_t_q <= (sec_t_q == 3'h5) ? 3'h0 : sec_t_q + 3'h1;
         end
         // Hours and minutes
         if (wr_hm)
         begin
            min_t_q    <= wdata_in[6:4];
            min_u_q    <= wdata_in[3:0];
            hr_t_q     <= wdata_in[13:12];
            hr_u_q     <= wdata_in[11:8];
            half_day_q <= wdata_in[`BIT_HALF_DAY] && !full_day_q;
         end
         else if (sec_wrap)
         begin
            min_u_q <= (min_u_q == 4'h9) ? 4'h0 : inc4(min_u_q);
            if (min_u_q == 4'h9)
               min_t_q <= (min_t_q == 3'h5) ? 3'h0 : min_t_q + 3'h1;
            if (min_wrap)
            begin
               if (full_day_q)
               begin
                  half_day_q <= 1'b0;
                  if (hr_last)
                  begin
                     hr_t_q <= 2'h0;
                     hr_u_q <= 4'h0;
                  end
                  else if (hr_u_q == 4'h9)
                  begin
                     hr_t_q <= hr_t_q + 2'h1;
                     hr_u_q <= 4'h0;
                  end
                  else
                     hr_u_q <= inc4(hr_u_q);
               end
               else
               begin
                  // 11 turns to 12 and flips the half day; 12 turns to 1
                  if (hr_t_q == 2'h1 && hr_u_q == 4'h1)
                  begin
                     hr_u_q     <= 4'h2;
                     half_day_q <= !half_day_q;
                  end
                  else if (hr_t_q == 2'h1 && hr_u_q == 4'h2)
                  begin
                     hr_t_q <= 2'h0;
                     hr_u_q <= 4'h1;
                  end
                  else if (hr_u_q == 4'h9)
                  begin
                     hr_t_q <= 2'h1;
                     hr_u_q <= 4'h0;
                  end
                  else
                     hr_u_q <= inc4(hr_u_q);
               end
            end
         end
         // Month and day
         if (wr_md)
         begin
            mo_t_q  <= wdata_in[12];
            mo_u_q  <= wdata_in[11:8];
            day_t_q <= wdata_in[5:4];
            day_u_q <= wdata_in[3:0];
         end
         else if (day_wrap)
         begin
            if (day_last)
            begin
               day_t_q <= 2'h0;
               day_u_q <= 4'h1;
               if (yr_step)
               begin
                  mo_t_q <= 1'b0;
                  mo_u_q <= 4'h1;
               end
               else if (mo_u_q == 4'h9)
               begin
                  mo_t_q <= 1'b1;
                  mo_u_q <= 4'h0;
               end
               else
                  mo_u_q <= inc4(mo_u_q);
            end
            else if (day_u_q == 4'h9)
            begin
               day_t_q <= day_t_q + 2'h1;
               day_u_q <= 4'h0;
            end
            else
               day_u_q <= inc4(day_u_q);
         end
         // Year and weekday
         if (wr_yw)
         begin
            week_q <= wdata_in[10:8];
            yr_t_q <= wdata_in[7:4];
            yr_u_q <= wdata_in[3:0];
         end
         else
         begin
            if (day_wrap)
               week_q <= (week_q == 3'h6) ? 3'h0 : week_q + 3'h1;
            if (yr_step)
            begin
               yr_u_q <= (yr_u_q == 4'h9) ? 4'h0 : inc4(yr_u_q);
               if (yr_u_q == 4'h9)
                  yr_t_q <= (yr_t_q == 4'h9) ? 4'h0 : inc4(yr_t_q);
            end
         end
      end
   end

   // ----------------------------------------
   // Event flags and request
   // ----------------------------------------
   reg [15:0] flag_set;
   reg [15:0] flags_d;

   always @*
   begin
      flag_set      = 16'h0000;
      flag_set[15]  = regulation_done_in;
      flag_set[14]  = lap_1;
      flag_set[13]  = lap_10;
      flag_set[12]  = lap_step;
      flag_set[8]   = alarm_in;
      flag_set[7]   = day_wrap;
      flag_set[6]   = min_wrap;
      flag_set[5]   = sec_wrap;
      flag_set[4]   = sec_step;
      flag_set[3]   = step && (div_q[6:0] == 7'h7f);
      flag_set[2]   = step && (div_q[5:0] == 6'h3f);
      flag_set[1]   = step && (div_q[4:0] == 5'h1f);
      flag_set[0]   = step && (div_q[2:0] == 3'h7);
      // A cause in the same cycle as a clear keeps the flag set
      flags_d = ((flags_q & ~(wr_flag ? wdata_in : 16'h0000)) | flag_set)
                & `FLAG_MASK;
   end

   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         flags_q  <= 16'h0000;
         enable_q <= 16'h0000;
         irq_out  <= 1'b0;
      end
      else
      begin
         flags_q <= flags_d;
         if (wr_en)
            enable_q <= wdata_in & `FLAG_MASK;
         irq_out <= |(flags_d & (wr_en ? wdata_in : enable_q));
      end
   end

   // ----------------------------------------
   // Read port, data in the cycle after the strobe
   // ----------------------------------------
   reg [15:0] rd_mux;

   always @*
   begin
      case (addr_in)
         `OFS_MAIN_CTRL:
            rd_mux = {9'h000, busy_q, 1'b0, full_day_q, 2'b00, div_clear_q, run_q};
         `OFS_LAP_CTRL:
            rd_mux = {lap_tenths_q, lap_hundredths_q, 7'h00, lap_go_q};
         `OFS_SEC_DIV:
            rd_mux = {1'b0, sec_t_q, sec_u_q, div_q};
         `OFS_HOUR_MIN:
            rd_mux = {1'b0, half_day_q && !full_day_q, hr_t_q, hr_u_q,
                      1'b0, min_t_q, min_u_q};
         `OFS_MONTH_DAY:
            rd_mux = {3'h0, mo_t_q, mo_u_q, 2'h0, day_t_q, day_u_q};
         `OFS_YEAR_WEEK:
            rd_mux = {5'h00, week_q, yr_t_q, yr_u_q};
         `OFS_EVENT_FLAGS:
            rd_mux = flags_q;
         `OFS_EVENT_ENABLE:
            rd_mux = enable_q;
         default:
            rd_mux = 16'h0000;
      endcase
   end

   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         rdata_out <= 16'h0000;
      else if (rd_in)
         rdata_out <= rd_mux;
      else
         rdata_out <= 16'h0000;
   end

endmodule

// ===== tb/rtc_regs_checker_assertions.sv
// Concurrent checks on the calendar clock register port
`timescale 1ns/10ps
`include "rtc_calendar_defs.vh"
module rtc_regs_checker
#(
   parameter DIV_TICK_CYCLES = 4,
   parameter LAP_TICK_CYCLES = 3
)
(
   input wire        clk_in,
   input wire        rst_n_in,
   input wire [2:0]  addr_in,
   input wire [15:0] wdata_in,
   input wire        wr_in,
   input wire        rd_in,
   input wire        alarm_in,
   input wire        regulation_done_in,
   input wire [15:0] rdata_out,
   input wire        irq_out
);
   wire rd_sec = rd_in && addr_in == `OFS_SEC_DIV;
   wire rd_hm  = rd_in && addr_in == `OFS_HOUR_MIN;
   wire rd_md  = rd_in && addr_in == `OFS_MONTH_DAY;
   wire rd_yw  = rd_in && addr_in == `OFS_YEAR_WEEK;
   wire rd_lap = rd_in && addr_in == `OFS_LAP_CTRL;
   wire rd_flg = rd_in && addr_in == `OFS_EVENT_FLAGS;
   wire wr_flg = wr_in && addr_in == `OFS_EVENT_FLAGS;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   // ----------------------------------------
   // Field ranges and reserved bits on reads
   // ----------------------------------------
   property p_lap; rd_lap |=> rdata_out[7:1] == 7'h00; endproperty
   property p_flg; rd_flg |=> rdata_out[11:9] == 3'h0; endproperty
   property p_sec;
      rd_sec |=> !rdata_out[15] && rdata_out[14:12] <= 3'h5 && rdata_out[11:8] <= 4'h9;
   endproperty
   property p_hm;
      rd_hm |=> !rdata_out[15] && !rdata_out[7] && rdata_out[6:4] <= 3'h5
                && rdata_out[3:0] <= 4'h9;
   endproperty
   // A zero month is never written, so a zero read means the counter broke
   property p_md;
      rd_md |=> rdata_out[15:13] == 3'h0 && rdata_out[7:6] == 2'h0 && rdata_out[12:8] != 5'h00;
   endproperty
   property p_yw; rd_yw |=> rdata_out[15:11] == 5'h00 && rdata_out[10:8] <= 3'h6; endproperty
   a_lap: assert property (p_lap) else $error("lap control low bits not zero");
   a_flg: assert property (p_flg) else $error("reserved flag bits set");
   a_sec: assert property (p_sec) else $error("seconds field out of range");
   a_hm: assert property (p_hm) else $error("minute field out of range");
   a_md: assert property (p_md) else $error("month field out of range");
   a_yw: assert property (p_yw) else $error("weekday field out of range");

   // ----------------------------------------
   // Side effects of writes and causes
   // ----------------------------------------
   property p_div;
      (wr_in && addr_in == `OFS_MAIN_CTRL && wdata_in[1] && !wdata_in[0]) ##1 !wr_in ##1 rd_sec
      |=> rdata_out[7:0] == 8'h00;
   endproperty
   property p_irq; wr_in && addr_in == `OFS_EVENT_ENABLE && wdata_in == 16'h0000 |=> !irq_out;
   endproperty
   property p_set; regulation_done_in ##[1:2] rd_flg |=> rdata_out[15]; endproperty
   property p_w1c;
      (wr_flg && wdata_in[8] && !alarm_in) ##1 !alarm_in ##1 (rd_flg && !alarm_in)
      |=> !rdata_out[8];
   endproperty
   a_div: assert property (p_div) else $error("divider stages not cleared");
   a_irq: assert property (p_irq) else $error("request with all enables off");
   a_set: assert property (p_set) else $error("regulation flag not set");
   a_w1c: assert property (p_w1c) else $error("alarm flag not cleared");

   c_set: cover property (regulation_done_in ##2 rd_flg);
   c_irq: cover property ($rose(irq_out));
   c_div: cover property (p_div);
endmodule

bind rtc_calendar_stopwatch_regs rtc_regs_checker
   #(.DIV_TICK_CYCLES(DIV_TICK_CYCLES), .LAP_TICK_CYCLES(LAP_TICK_CYCLES)) chk (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .alarm_in(alarm_in), .regulation_done_in(regulation_done_in),
   .rdata_out(rdata_out), .irq_out(irq_out));

// ===== tb/rtc_calendar_stopwatch_regs_test.sv
// Self-checking bench for the calendar clock register port
`timescale 1ns/10ps
`include "rtc_calendar_defs.vh"
module rtc_calendar_stopwatch_regs_test;
   reg         clk_in = 1'b0;
   reg         rst_n_in = 1'b0;
   reg  [2:0]  addr_in = 3'h0;
   reg  [15:0] wdata_in = 16'h0000;
   reg         wr_in = 1'b0;
   reg         rd_in = 1'b0;
   reg         alarm_in = 1'b0;
   reg         regulation_done_in = 1'b0;
   wire [15:0] rdata_out;
   wire        irq_out;
   integer     n_mismatch = 0;
   integer     tests_run = 0;
   integer     seed = 32'hec0f7c8e;
   integer     i;
   reg  [31:0] r;
   reg  [31:0] e;
   reg  [15:0] v;
   reg         rd_d = 1'b0;
   reg  [31:0] q [$];

   always #2.5 clk_in = ~clk_in;

   // Short counts keep one simulated second near a thousand clocks
   rtc_calendar_stopwatch_regs #(.DIV_TICK_CYCLES(4), .LAP_TICK_CYCLES(3)) dut (
      .clk_in             (clk_in),
      .rst_n_in           (rst_n_in),
      .addr_in            (addr_in),
      .wdata_in           (wdata_in),
      .wr_in              (wr_in),
      .rd_in              (rd_in),
      .alarm_in           (alarm_in),
      .regulation_done_in (regulation_done_in),
      .rdata_out          (rdata_out),
      .irq_out            (irq_out)
   );

   // ----------------------------------------
   // Bus tasks and result watcher
   // ----------------------------------------
   task miss(input string m);
   begin
      $display("ERROR %0t %s", $time, m);
      n_mismatch = n_mismatch + 1;
   end
   endtask

   task conclude;
   begin
      if (n_mismatch == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask

   task wr(input [2:0] a, input [15:0] d);
   begin
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   end
   endtask

   // Expected value and mask go on the queue; the watcher compares
   task rd(input [2:0] a, input [15:0] x, input [15:0] m);
   begin
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      q.push_back({m, x});
      @(posedge clk_in);
      rd_in <= 1'b0;
   end
   endtask

   always @(posedge clk_in) rd_d <= rd_in;

   always @(negedge clk_in)
   begin
      if (rd_d)
      begin
         e = q.pop_front();
         tests_run = tests_run + 1;
         if ((rdata_out & e[31:16]) !== e[15:0])
            miss("read data mismatch");
      end
   end

   task chk_irq(input x);
   begin
      @(negedge clk_in);
      tests_run = tests_run + 1;
      if (irq_out !== x)
         miss("interrupt level mismatch");
   end
   endtask

   // One simulated second is about 1024 clocks, so 1300 covers any divider phase
   task wait_irq;
   begin
      i = 0;
      while (irq_out !== 1'b1 && i < 1300)
      begin
         @(negedge clk_in);
         i = i + 1;
      end
      if (irq_out !== 1'b1)
      begin
         miss("timeout waiting for day event");
         conclude;
      end
   end
   endtask

   // Set a time one second before midnight, run and check the whole cascade
   task roll(input m, input [15:0] hm, yw, md, ehm, eyw, emd);
   begin
      wr(0, {11'h0, m, 4'h0});
      wr(7, 16'h0080);
      wr(6, 16'hffff);
      wr(2, 16'h5900);
      wr(3, hm);
      wr(4, md);
      wr(5, yw);
      wr(0, {11'h0, m, 4'h1});
      wait_irq;
      rd(0, 16'h0040, 16'h0040);
      rd(2, 16'h0000, 16'hff00);
      rd(3, ehm, 16'hffff);
      rd(4, emd, 16'hffff);
      rd(5, eyw, 16'hffff);
      rd(6, 16'h00f0, 16'h00f0);
      rd(0, 16'h0000, 16'h0040);
      wr(0, {11'h0, m, 4'h0});
      wr(6, 16'hffff);
      chk_irq(1'b0);
   end
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      for (i = 0; i < 8; i = i + 1)
         rd(i, (i == 3) ? 16'h1200 : (i == 4) ? 16'h0101 : 16'h0000, 16'hffff);
      repeat (4)
      begin
         r = $random(seed);
         v = {5'h00, r[2:0] % 3'd7, r[7:4] % 4'd10, r[11:8] % 4'd10};
         wr(5, v);
         rd(5, v, 16'hffff);
         v = {1'b0, r[13], 2'h0, {2'h0, r[15:14]} + 4'd1, 1'b0, r[18:16] % 3'd6, r[22:19] % 4'd10};
         wr(3, v);
         rd(3, v, 16'hffff);
      end
      wr(3, 16'h4130);
      wr(0, 16'h0010);
      rd(3, 16'h0130, 16'hffff);
      wr(3, 16'h4130);
      rd(3, 16'h0130, 16'hffff);
      roll(1'b1, 16'h2359, 16'h0699, 16'h1231, 16'h0000, 16'h0000, 16'h0101);
      roll(1'b1, 16'h2359, 16'h0201, 16'h0228, 16'h0000, 16'h0301, 16'h0301);
      roll(1'b0, 16'h5159, 16'h0304, 16'h0228, 16'h1200, 16'h0404, 16'h0229);
      roll(1'b1, 16'h2359, 16'h0510, 16'h0430, 16'h0000, 16'h0610, 16'h0501);
      wr(0, 16'h0002);
      rd(2, 16'h0000, 16'h00ff);
      rd(2, 16'h0000, 16'h00ff);
      wr(2, 16'h12ff);
      rd(2, 16'h1200, 16'hffff);
      // Lap timer: clear while running, freeze, clear while idle, resume
      wr(1, 16'h0001);
      repeat (45) @(posedge clk_in);
      rd(6, 16'h1000, 16'h1000);
      wr(1, 16'h0011);
      // A running lap timer may already have taken one step after the clear
      rd(1, 16'h0001, 16'hfeff);
      wr(1, 16'h0000);
      repeat (10) @(posedge clk_in);
      wr(6, 16'hffff);
      repeat (20) @(posedge clk_in);
      rd(6, 16'h0000, 16'h7000);
      wr(1, 16'h0010);
      rd(1, 16'h0000, 16'hffff);
      wr(1, 16'h0001);
      repeat (40) @(posedge clk_in);
      rd(6, 16'h3000, 16'h3000);
      wr(1, 16'h0000);
      // Outside causes, enables and write-one-to-clear
      r = $random(seed);
      v = r[15:0] | 16'h0100;
      wr(7, v);
      rd(7, v & `FLAG_MASK, 16'hffff);
      @(posedge clk_in);
      alarm_in <= 1'b1;
      regulation_done_in <= 1'b1;
      @(posedge clk_in);
      alarm_in <= 1'b0;
      regulation_done_in <= 1'b0;
      rd(6, 16'h8100, 16'h8100);
      chk_irq(1'b1);
      wr(6, 16'h0000);
      rd(6, 16'h8100, 16'h8100);
      wr(6, 16'h0100);
      rd(6, 16'h8000, 16'h8100);
      wr(7, 16'h0000);
      chk_irq(1'b0);
      // Second reset in mid-run
      wr(0, 16'h0001);
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(3, 16'h1200, 16'hffff);
      rd(0, 16'h0000, 16'hffff);
      repeat (2) @(posedge clk_in);
      conclude;
   end
endmodule
